// ### design/wnf_cfg.svh
`ifndef WNF_CFG_SVH
`define WNF_CFG_SVH
// Memory commands legal in wide mode
`define WNF_CMD_MEM_RD 4'h6
`define WNF_CMD_MEM_WR 4'h7
`define WNF_CMD_MEM_RDM 4'hC
`define WNF_CMD_MEM_RDL 4'hE
`define WNF_CMD_WR_BIT 0
// Lane and field positions
`define WNF_HI 63:32
`define WNF_LO 31:0
`define WNF_BE_HI 7:4
`define WNF_BE_LO 3:0
`define WNF_ADDR_ALIGN 2:0
`define WNF_ALIGN_OK 3'h0
// Synchroniser vector layout
`define WNF_SYNC_W 69
`define WNF_PIN_GNT 68
`define WNF_PIN_DEVSEL 67
`define WNF_PIN_TRDY 66
`define WNF_PIN_STOP 65
`define WNF_PIN_ACK 64
// Read buffer: tag bit above a quadword
`define WNF_FIFO_DEPTH 16
`define WNF_FIFO_W 65
`define WNF_TAG_BIT 64
// Counts and steps
`define WNF_LAST_PH 8'h01
`define WNF_NO_PH 8'h00
`define WNF_MIN_WIDE_DW 16'h0004
`define WNF_LEN_MAX 16'h00FF
`define WNF_STEP_DW 32'h00000004
`define WNF_STEP_QW 32'h00000008
`define WNF_PIN_OFF 1'b1
`endif

// ### design/wnf_pkg.sv
package wnf_pkg;
  typedef enum logic [7:0] {
    C_IDLE = 8'h01, C_ARB = 8'h02, C_ADDR = 8'h04, C_DATA = 8'h08,
    C_MUXB = 8'h10, C_MUXD = 8'h20, C_GAP = 8'h40, C_END = 8'h80
  } wnf_core_e;
  typedef enum logic [4:0] {
    A_IDLE = 5'h01, A_REQ = 5'h02, A_WAIT = 5'h04, A_DRAIN = 5'h08, A_FIN = 5'h10
  } wnf_app_e;
  typedef logic [63:0] wnf_qword_t;
  typedef logic [7:0] wnf_len_t;
endpackage

// ### design/wnf_link_if.sv
`timescale 1ns/1ps
interface wnf_link_if;
  logic req;
  logic wide_transfer_request;
  logic [3:0] cmd;
  logic [31:0] addr;
  wnf_pkg::wnf_len_t len;
  logic [7:0] be;
  wnf_pkg::wnf_qword_t wdata;
  logic [31:0] cur_addr;
  logic busy;
  logic done;
  logic retry;
  wnf_pkg::wnf_len_t moved;
  logic narrow_target_flag;
  wnf_pkg::wnf_qword_t user_addr_data_bus;
  logic rnarrow;
  logic rvalid;
  logic rready;
  modport core (input req, wide_transfer_request, cmd, addr, len, be, wdata, rready,
    output cur_addr, busy, done, retry, moved, narrow_target_flag, user_addr_data_bus, rnarrow, rvalid);
  modport app (output req, wide_transfer_request, cmd, addr, len, be, wdata, rready,
    input cur_addr, busy, done, retry, moved, narrow_target_flag, user_addr_data_bus, rnarrow, rvalid);
endinterface

// ### design/wnf_fifo.sv
`timescale 1ns/1ps
`include "wnf_cfg.svh"
module wnf_fifo #(
  parameter int W = `WNF_FIFO_W,
  parameter int DEPTH = `WNF_FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rp_r];
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  // Storage has no reset, pointers do
  always_ff @(posedge clk) begin
    if (ce && push) mem[wp_r] <= in_data;
  end

  // Pointers and registered flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      in_ready <= cnt_nxt != (AW+1)'(DEPTH);
      out_valid <= cnt_nxt != '0;
    end
  end
endmodule // wnf_fifo

// ### design/wnf_app_end.sv
`timescale 1ns/1ps
`include "wnf_cfg.svh"
module wnf_app_end (
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic CE,
  // Link toward the bus interface
  wnf_link_if.app LNK,
  // Job request
  input wire logic START,
  input wire logic [31:0] START_ADDR,
  input wire logic [15:0] DWORDS,
  input wire logic [3:0] CMD,
  input wire logic [7:0] BE,
  input wire logic [31:0] SEED,
  // Read sink
  input wire logic SNK_READY,
  output logic [63:0] SNK_DATA,
  output logic SNK_VALID,
  // Job status
  output logic BUSY,
  output logic DONE
);
  wnf_pkg::wnf_app_e st_r;
  logic [31:0] addr_r, seed_r;
  logic [15:0] left_r, cnt;
  logic [3:0] cmd_r;
  logic [7:0] be_r;
  logic narrow_r, was_wide_r, half_r, mem_cmd, aligned, go_wide, pop, qstep;
  logic [31:0] lo_r;

  // Wide mode only for aligned memory bursts of two quadwords or more
  assign mem_cmd = (cmd_r == `WNF_CMD_MEM_RD) || (cmd_r == `WNF_CMD_MEM_WR) ||
                   (cmd_r == `WNF_CMD_MEM_RDM) || (cmd_r == `WNF_CMD_MEM_RDL);
  assign aligned = addr_r[`WNF_ADDR_ALIGN] == `WNF_ALIGN_OK;
  assign go_wide = mem_cmd && aligned && !narrow_r && left_r >= `WNF_MIN_WIDE_DW;
  assign cnt = go_wide ? {1'b0, left_r[15:1]} : left_r;
  assign qstep = was_wide_r && !LNK.narrow_target_flag;
  assign pop = LNK.rvalid && LNK.rready;
  assign LNK.cmd = cmd_r;
  assign LNK.addr = addr_r;
  assign LNK.be = be_r;

  // Job sequencer; a retry reissues the identical request
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= wnf_pkg::A_IDLE;
      addr_r <= '0;
      left_r <= '0;
      cmd_r <= '0;
      be_r <= '0;
      seed_r <= '0;
      narrow_r <= 1'b0;
      was_wide_r <= 1'b0;
      LNK.req <= 1'b0;
      LNK.wide_transfer_request <= 1'b0;
      LNK.len <= '0;
    end else if (CE) begin
      LNK.req <= 1'b0;
      LNK.wide_transfer_request <= 1'b0;
      case (st_r)
        wnf_pkg::A_IDLE: if (START) begin
          addr_r <= START_ADDR;
          left_r <= DWORDS;
          cmd_r <= CMD;
          be_r <= BE;
          seed_r <= SEED;
          narrow_r <= 1'b0;
          st_r <= (DWORDS == '0) ? wnf_pkg::A_DRAIN : wnf_pkg::A_REQ;
        end
        wnf_pkg::A_REQ: begin
          LNK.wide_transfer_request <= go_wide;
          LNK.req <= !go_wide;
          was_wide_r <= go_wide;
          LNK.len <= (cnt > `WNF_LEN_MAX) ? 8'hFF : cnt[7:0];
          st_r <= wnf_pkg::A_WAIT;
        end
        wnf_pkg::A_WAIT: if (LNK.done) begin
          if (LNK.retry) begin
            st_r <= wnf_pkg::A_REQ;
          end else begin
            addr_r <= addr_r + 32'(32'(LNK.moved) * (qstep ? `WNF_STEP_QW : `WNF_STEP_DW));
            left_r <= left_r - (qstep ? {7'h00, LNK.moved, 1'b0} : {8'h00, LNK.moved});
            narrow_r <= narrow_r | LNK.narrow_target_flag;
            if (left_r == (qstep ? {7'h00, LNK.moved, 1'b0} : {8'h00, LNK.moved})) st_r <= wnf_pkg::A_DRAIN;
            else st_r <= wnf_pkg::A_REQ;
          end
        end
        wnf_pkg::A_DRAIN: if (!LNK.rvalid) st_r <= wnf_pkg::A_FIN;
        wnf_pkg::A_FIN: st_r <= wnf_pkg::A_IDLE;
        default: st_r <= wnf_pkg::A_IDLE;
      endcase
    end
  end

  // Write pattern follows the interface's current bus address
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) LNK.wdata <= '0;
    else if (CE) LNK.wdata <= {(LNK.cur_addr + `WNF_STEP_DW) ^ seed_r, LNK.cur_addr ^ seed_r};
  end

  // Read assembly: single-dword words pair up low then high
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      LNK.rready <= 1'b0;
      half_r <= 1'b0;
      lo_r <= '0;
      SNK_DATA <= '0;
      SNK_VALID <= 1'b0;
    end else if (CE) begin
      LNK.rready <= SNK_READY;
      SNK_VALID <= 1'b0;
      if (pop && LNK.rnarrow) begin
        if (half_r) begin
          SNK_DATA <= {LNK.user_addr_data_bus[`WNF_LO], lo_r};
          SNK_VALID <= 1'b1;
        end
        lo_r <= LNK.user_addr_data_bus[`WNF_LO];
        half_r <= !half_r;
      end else if (pop) begin
        SNK_DATA <= LNK.user_addr_data_bus;
        SNK_VALID <= 1'b1;
      end else if (st_r == wnf_pkg::A_DRAIN && !LNK.rvalid && half_r) begin
        SNK_DATA <= {32'h00000000, lo_r}; // Odd dword closes the job
        SNK_VALID <= 1'b1;
        half_r <= 1'b0;
      end
    end
  end

  // Job status
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      BUSY <= 1'b0;
      DONE <= 1'b0;
    end else if (CE) begin
      BUSY <= (st_r != wnf_pkg::A_IDLE) && (st_r != wnf_pkg::A_FIN);
      DONE <= st_r == wnf_pkg::A_FIN;
    end
  end
endmodule // wnf_app_end

// ### design/wnf_core_end.sv
// Function
// - Never request wide single-phase transfers
// - Wide transfers start quadword aligned
// - Wide transfers use memory commands only
// - Narrow target: stop after two dword phases
// - After retry reissue identical wide request
// - Raise narrow flag without wide acknowledge
// - Narrow flag selects dword pointer steps
// - Continue leftover data as 32-bit agent
// - Read fallback: wait state copies upper enables
// - Write fallback: next cycle copies upper data
// - Disconnect after first phase: no lane copy
// - Fallback read uses lower half only
// - Watch narrow flag through each transaction
// - Prefer 32-bit continuation after fallback
// - Misaligned continuation must be 32-bit
// - Interface muxes write data lanes itself
// - Wide request arbitrates, then starts wide
`timescale 1ns/1ps
`include "wnf_cfg.svh"
module wnf_core_end #(
  parameter int DEPTH = `WNF_FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic CE,
  // Link toward the user application
  wnf_link_if.core LNK,
  // Bus arbitration, active low
  output logic REQ_N,
  input wire logic GNT_N,
  // Bus control, active low
  output logic FRAME_N,
  output logic IRDY_N,
  output logic WIDE_REQ_PIN_N,
  input wire logic DEVSEL_N,
  input wire logic TRDY_N,
  input wire logic STOP_N,
  input wire logic WIDE_ACK_PIN_N,
  // Address/data lanes
  input wire logic [63:0] AD_IN,
  output logic [63:0] AD_OUT,
  output logic AD_OE,
  // Command and byte enables
  output logic [7:0] BUS_CMD_BYTE_ENABLE_PINS,
  output logic BUS_CMD_BYTE_ENABLE_PINS_OE
);
  wnf_pkg::wnf_core_e st_r, st_nxt;
  logic [`WNF_SYNC_W-1:0] meta_r, pin_r;
  logic gnt, devsel, trdy, stop, ack64;
  logic wide_r, write_r, flag_r, half_r, gap_r, fb, narrow_now, ph_done, term_nd, in_frame;
  logic [3:0] cmd_r;
  logic [7:0] be_r;
  logic [31:0] cur_r;
  wnf_pkg::wnf_len_t left_r, moved_r;
  logic fifo_in_ready;

  // Two-stage synchroniser on every bus input
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      meta_r <= '0;
      pin_r <= '0;
    end else if (CE) begin
      meta_r <= {~GNT_N, ~DEVSEL_N, ~TRDY_N, ~STOP_N, ~WIDE_ACK_PIN_N, AD_IN};
      pin_r <= meta_r;
    end
  end

  assign gnt = pin_r[`WNF_PIN_GNT];
  assign devsel = pin_r[`WNF_PIN_DEVSEL];
  assign trdy = pin_r[`WNF_PIN_TRDY];
  assign stop = pin_r[`WNF_PIN_STOP];
  assign ack64 = pin_r[`WNF_PIN_ACK];

  // A claim without the wide acknowledge marks a narrow target
  assign fb = wide_r && devsel && !ack64;
  assign narrow_now = !wide_r || fb || flag_r;
  assign ph_done = (st_r == wnf_pkg::C_DATA) && !IRDY_N && devsel && trdy;
  assign term_nd = (st_r == wnf_pkg::C_DATA) && stop && !trdy;
  assign in_frame = (st_nxt != wnf_pkg::C_IDLE) && (st_nxt != wnf_pkg::C_ARB) && (st_nxt != wnf_pkg::C_END);

  // Transaction sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      wnf_pkg::C_IDLE: if (LNK.req || LNK.wide_transfer_request) st_nxt = wnf_pkg::C_ARB;
      wnf_pkg::C_ARB: if (gnt) st_nxt = wnf_pkg::C_ADDR;
      wnf_pkg::C_ADDR: st_nxt = wnf_pkg::C_DATA;
      wnf_pkg::C_DATA: begin
        if (term_nd) begin
          st_nxt = wnf_pkg::C_END;
        end else if (ph_done && (fb || flag_r)) begin
          // Second narrow phase or a disconnect ends it here
          if (half_r || stop) st_nxt = wnf_pkg::C_END;
          else st_nxt = wnf_pkg::C_MUXB;
        end else if (ph_done) begin
          if (stop || left_r == `WNF_LAST_PH) st_nxt = wnf_pkg::C_END;
          else st_nxt = wnf_pkg::C_GAP;
        end
      end
      wnf_pkg::C_MUXB: st_nxt = write_r ? wnf_pkg::C_MUXD : wnf_pkg::C_DATA;
      wnf_pkg::C_MUXD: st_nxt = wnf_pkg::C_DATA;
      wnf_pkg::C_GAP: if (gap_r) st_nxt = wnf_pkg::C_DATA;
      wnf_pkg::C_END: st_nxt = wnf_pkg::C_IDLE;
      default: st_nxt = wnf_pkg::C_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) st_r <= wnf_pkg::C_IDLE;
    else if (CE) st_r <= st_nxt;
  end

  // Gap lasts two cycles so the next write word has settled
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) gap_r <= 1'b0;
    else if (CE) gap_r <= (st_r == wnf_pkg::C_GAP) && !gap_r;
  end

  // Request capture and phase bookkeeping
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      wide_r <= 1'b0;
      write_r <= 1'b0;
      cmd_r <= '0;
      be_r <= '0;
      cur_r <= '0;
      left_r <= '0;
      moved_r <= '0;
      half_r <= 1'b0;
    end else if (CE) begin
      if (st_r == wnf_pkg::C_IDLE && st_nxt == wnf_pkg::C_ARB) begin
        wide_r <= LNK.wide_transfer_request;
        write_r <= LNK.cmd[`WNF_CMD_WR_BIT];
        cmd_r <= LNK.cmd;
        be_r <= LNK.be;
        cur_r <= LNK.addr;
        left_r <= LNK.len;
        moved_r <= '0;
        half_r <= 1'b0;
      end else if (ph_done) begin
        cur_r <= cur_r + (narrow_now ? `WNF_STEP_DW : `WNF_STEP_QW);
        left_r <= left_r - `WNF_LAST_PH;
        moved_r <= moved_r + `WNF_LAST_PH;
        half_r <= half_r | fb | flag_r;
      end
    end
  end

  // Narrow-target flag: cleared at the next start, set on a narrow claim
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) flag_r <= 1'b0;
    else if (CE) begin
      if (st_r == wnf_pkg::C_DATA && fb) flag_r <= 1'b1;
      else if (st_r == wnf_pkg::C_IDLE && st_nxt == wnf_pkg::C_ARB) flag_r <= 1'b0;
    end
  end

  // Bus control pins; reads stall while the buffer has no room
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      REQ_N <= `WNF_PIN_OFF;
      FRAME_N <= `WNF_PIN_OFF;
      IRDY_N <= `WNF_PIN_OFF;
      WIDE_REQ_PIN_N <= `WNF_PIN_OFF;
    end else if (CE) begin
      REQ_N <= st_nxt != wnf_pkg::C_ARB;
      FRAME_N <= !in_frame;
      WIDE_REQ_PIN_N <= !(in_frame && wide_r);
      IRDY_N <= !(st_nxt == wnf_pkg::C_DATA && (write_r || (fifo_in_ready && !(ph_done && !write_r))));
    end
  end

  // Address, data and byte-enable lanes
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      AD_OUT <= '0;
      AD_OE <= 1'b0;
      BUS_CMD_BYTE_ENABLE_PINS <= '0;
      BUS_CMD_BYTE_ENABLE_PINS_OE <= 1'b0;
    end else if (CE) begin
      BUS_CMD_BYTE_ENABLE_PINS_OE <= in_frame;
      if (st_nxt == wnf_pkg::C_ADDR) begin
        AD_OUT <= {32'h00000000, cur_r}; // Upper half driven, not used
        AD_OE <= 1'b1;
        BUS_CMD_BYTE_ENABLE_PINS <= {4'h0, cmd_r};
      end else if ((st_r == wnf_pkg::C_ADDR || st_r == wnf_pkg::C_GAP) && st_nxt == wnf_pkg::C_DATA) begin
        AD_OUT <= LNK.wdata;
        AD_OE <= write_r;
        BUS_CMD_BYTE_ENABLE_PINS <= be_r;
      end else if (st_nxt == wnf_pkg::C_MUXB) begin
        BUS_CMD_BYTE_ENABLE_PINS[`WNF_BE_LO] <= BUS_CMD_BYTE_ENABLE_PINS[`WNF_BE_HI];
      end else if (st_nxt == wnf_pkg::C_MUXD) begin
        AD_OUT[`WNF_LO] <= AD_OUT[`WNF_HI];
      end else if (!in_frame) begin
        AD_OE <= 1'b0;
      end
    end
  end

  // Completion report, held by flops for the link
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      LNK.busy <= 1'b0;
      LNK.done <= 1'b0;
      LNK.retry <= 1'b0;
    end else if (CE) begin
      LNK.busy <= st_nxt != wnf_pkg::C_IDLE;
      LNK.done <= st_r == wnf_pkg::C_END;
      LNK.retry <= (st_r == wnf_pkg::C_END) && (moved_r == `WNF_NO_PH);
    end
  end

  assign LNK.cur_addr = cur_r;
  assign LNK.moved = moved_r;
  assign LNK.narrow_target_flag = flag_r;

  // Read buffer; tag marks words that carry one dword in the low lanes
  wnf_fifo #(.W(`WNF_FIFO_W), .DEPTH(DEPTH)) u_rdbuf (
    .clk(MCLK),
    .rst_n(RSTN),
    .ce(CE),
    .in_valid(ph_done && !write_r),
    .in_ready(fifo_in_ready),
    .in_data({narrow_now, pin_r[63:0]}),
    .out_valid(LNK.rvalid),
    .out_ready(LNK.rready),
    .out_data({LNK.rnarrow, LNK.user_addr_data_bus})
  );
endmodule // wnf_core_end

// ### tb/wnf_link_asserts.sv
`timescale 1ns/1ps
`include "wnf_cfg.svh"
module wnf_link_asserts (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // Request side
  input wire logic req,
  input wire logic wide_transfer_request,
  input wire logic [3:0] cmd,
  input wire logic [31:0] addr,
  input wire wnf_pkg::wnf_len_t len,
  // Answer side
  input wire logic busy,
  input wire logic done,
  input wire logic retry,
  input wire wnf_pkg::wnf_len_t moved,
  input wire logic narrow_target_flag,
  input wire logic [31:0] cur_addr,
  input wire logic rvalid
);
  logic take;
  logic [44:0] last_r;
  logic retry_pend_r;
  // Request accepted by an idle core
  assign take = (req || wide_transfer_request) && !busy;
  // Remember the last request so a reissue can be compared
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) last_r <= 45'h0;
    else if (take) last_r <= {wide_transfer_request, cmd, addr, len};
  end
  // Retry leaves a reissue owed
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) retry_pend_r <= 1'b0;
    else if (take) retry_pend_r <= 1'b0;
    else if (done && retry) retry_pend_r <= 1'b1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  property p_wide_burst; wide_transfer_request |-> len >= 8'h02; endproperty
  a_wide_burst: assert property (p_wide_burst) else $error("wide single phase");
  property p_wide_align; wide_transfer_request |-> addr[2:0] == 3'h0; endproperty
  a_wide_align: assert property (p_wide_align) else $error("wide unaligned");
  property p_wide_cmd;
    wide_transfer_request |-> cmd inside {`WNF_CMD_MEM_RD, `WNF_CMD_MEM_WR, `WNF_CMD_MEM_RDM, `WNF_CMD_MEM_RDL};
  endproperty
  a_wide_cmd: assert property (p_wide_cmd) else $error("wide non memory cmd");
  property p_fall_len; done && narrow_target_flag |-> moved inside {8'h01, 8'h02} && !retry; endproperty
  a_fall_len: assert property (p_fall_len) else $error("fallback moved too much");
  property p_retry_same; take && retry_pend_r |-> {wide_transfer_request, cmd, addr, len} == last_r; endproperty
  a_retry_same: assert property (p_retry_same) else $error("reissue differs");
  property p_narrow_step;
    busy && $past(busy) && narrow_target_flag && $past(narrow_target_flag) && cur_addr != $past(cur_addr)
      |-> cur_addr == $past(cur_addr) + 32'h4;
  endproperty
  a_narrow_step: assert property (p_narrow_step) else $error("narrow step not 4");
  property p_take_busy; take |=> busy && !done; endproperty
  a_take_busy: assert property (p_take_busy) else $error("request not started");
  property p_flag_clear; take |=> !narrow_target_flag; endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag kept into new request");
  property p_flag_hold; $fell(narrow_target_flag) |-> $past(take); endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped early");
  // Main scenarios reached
  c_wide: cover property (take && wide_transfer_request);
  c_retry: cover property (done && retry);
  c_fall: cover property (done && narrow_target_flag);
  c_read: cover property (rvalid);
endmodule // wnf_link_asserts

// ### tb/wide_initiator_narrow_fallback_tb.sv
`timescale 1ns/1ps
`include "wnf_cfg.svh"
module wide_initiator_narrow_fallback_tb;
  logic MCLK = 1'b0;
  logic RSTN = 1'b0;
  logic START = 1'b0, SNK_READY = 1'b0, GNT_N = 1'b1, DEVSEL_N = 1'b1, TRDY_N = 1'b1, STOP_N = 1'b1;
  logic WIDE_ACK_PIN_N = 1'b1, REQ_N, FRAME_N, IRDY_N, WIDE_REQ_PIN_N, SNK_VALID, BUSY, DONE, AD_OE;
  logic [31:0] START_ADDR = 32'h0, SEED = 32'h13579BDF;
  logic [15:0] DWORDS = 16'h0;
  logic [3:0] CMD = 4'h0;
  logic [7:0] BE = 8'hC3, CBE;
  logic [63:0] AD_IN = 64'h0, AD_OUT, SNK_DATA;
  int error_cnt = 0, num_checks = 0, hold = 0, quiet = 0, rk = 0, n_wide = 0, ph_cnt = 0;
  bit t_wide, t_disc, t_retry, flag_seen, fr_q = 1, ir_q = 1;
  logic [72:0] q_ph[$];
  logic [31:0] q_adr[$];
  logic [63:0] q_snk[$];
  int q_tph[$];
  localparam logic [31:0] A0 = 32'h00001000;
  wnf_link_if i_wnf_link_if ();
  wnf_app_end i_wnf_app_end (.MCLK(MCLK), .RSTN(RSTN), .CE(1'b1), .LNK(i_wnf_link_if), .START(START),
    .START_ADDR(START_ADDR), .DWORDS(DWORDS), .CMD(CMD), .BE(BE), .SEED(SEED), .SNK_READY(SNK_READY),
    .SNK_DATA(SNK_DATA), .SNK_VALID(SNK_VALID), .BUSY(BUSY), .DONE(DONE));
  wnf_core_end i_wnf_core_end (.MCLK(MCLK), .RSTN(RSTN), .CE(1'b1), .LNK(i_wnf_link_if), .REQ_N(REQ_N),
    .GNT_N(GNT_N), .FRAME_N(FRAME_N), .IRDY_N(IRDY_N), .WIDE_REQ_PIN_N(WIDE_REQ_PIN_N), .DEVSEL_N(DEVSEL_N),
    .TRDY_N(TRDY_N), .STOP_N(STOP_N), .WIDE_ACK_PIN_N(WIDE_ACK_PIN_N), .AD_IN(AD_IN), .AD_OUT(AD_OUT),
    .AD_OE(AD_OE), .BUS_CMD_BYTE_ENABLE_PINS(CBE), .BUS_CMD_BYTE_ENABLE_PINS_OE());
  wnf_link_asserts i_wnf_link_asserts (.MCLK(MCLK), .RSTN(RSTN), .req(i_wnf_link_if.req),
    .wide_transfer_request(i_wnf_link_if.wide_transfer_request), .cmd(i_wnf_link_if.cmd),
    .addr(i_wnf_link_if.addr), .len(i_wnf_link_if.len), .busy(i_wnf_link_if.busy), .done(i_wnf_link_if.done),
    .retry(i_wnf_link_if.retry), .moved(i_wnf_link_if.moved),
    .narrow_target_flag(i_wnf_link_if.narrow_target_flag), .cur_addr(i_wnf_link_if.cur_addr),
    .rvalid(i_wnf_link_if.rvalid));
  always #2.5 MCLK = ~MCLK;
  function automatic logic [31:0] pat(input int k);
    return 32'h5A5A0000 + 32'(k);
  endfunction
  // Target: held 2 cycles, a third would be counted again after the read mux wait
  // Idle lanes toggle so stale data never matches
  always @(negedge MCLK) begin
    GNT_N <= REQ_N;
    DEVSEL_N <= FRAME_N;
    WIDE_ACK_PIN_N <= !(t_wide && !WIDE_REQ_PIN_N && !FRAME_N);
    SNK_READY <= ~SNK_READY; // Sink stalls every other cycle
    if (hold > 0) begin
      hold--;
      if (hold == 0) begin
        TRDY_N <= 1'b1;
        STOP_N <= 1'b1;
        quiet = 4;
      end
    end else if (quiet > 0) quiet--;
    else if (!FRAME_N && !IRDY_N) begin
      hold = 2;
      TRDY_N <= t_retry;
      STOP_N <= !(t_retry || t_disc);
      AD_IN <= {~pat(rk), pat(rk)};
      rk++;
      t_retry = 0;
    end
    if (hold == 0) AD_IN <= ~AD_IN;
    // Bus and sink observation
    if (fr_q && !FRAME_N) q_adr.push_back(AD_OUT[31:0]);
    if (fr_q && !FRAME_N && !WIDE_REQ_PIN_N) n_wide++;
    if (!fr_q && FRAME_N) q_tph.push_back(ph_cnt);
    if (!fr_q && FRAME_N) ph_cnt = 0;
    if (ir_q && !IRDY_N) q_ph.push_back({AD_OE, CBE, AD_OUT});
    if (ir_q && !IRDY_N) ph_cnt++;
    if (SNK_VALID === 1'b1) q_snk.push_back(SNK_DATA);
    if (i_wnf_link_if.narrow_target_flag === 1'b1) flag_seen = 1;
    fr_q = FRAME_N;
    ir_q = IRDY_N;
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // One application job against a target of the chosen kind
  task automatic job(input logic [31:0] a, input logic [15:0] dw, input logic [3:0] c, input bit w, d, r);
    int n;
    @(negedge MCLK);
    t_wide = w;
    t_disc = d;
    t_retry = r;
    rk = 0;
    n_wide = 0;
    flag_seen = 0;
    q_ph.delete();
    q_adr.delete();
    q_snk.delete();
    q_tph.delete();
    START_ADDR <= a;
    DWORDS <= dw;
    CMD <= c;
    START <= 1'b1;
    @(negedge MCLK) START <= 1'b0;
    @(negedge MCLK);
    chk("job_busy", 64'h1, 64'(BUSY));
    n = 0;
    while (DONE !== 1'b1 && n < 4000) begin
      @(negedge MCLK);
      n++;
    end
    chk("job_done", 64'h1, 64'(DONE));
  endtask
  // All memory commands go wide on a wide target
  task automatic scen_cmds;
    logic [3:0] cl [4] = '{`WNF_CMD_MEM_RD, `WNF_CMD_MEM_WR, `WNF_CMD_MEM_RDM, `WNF_CMD_MEM_RDL};
    for (int i = 0; i < 4; i++) begin
      job(A0, 16'h4, cl[i], 1, 0, 0);
      chk("wide_cnt", 64'h1, 64'(n_wide));
      chk("flag_wide", 64'h0, 64'(flag_seen));
      chk("ad_oe", 64'(i == 1), 64'(q_ph[0][72]));
      if (i == 1) chk("wr_qw", {A0 ^ SEED ^ 32'h4, A0 ^ SEED}, q_ph[0][63:0]);
      else chk("rd_qw", {~pat(1), pat(1)}, q_snk[1]);
    end
  endtask
  task automatic scen_fb_write;
    job(A0, 16'h4, `WNF_CMD_MEM_WR, 0, 0, 0);
    chk("flag", 64'h1, 64'(flag_seen));
    chk("wide_cnt", 64'h1, 64'(n_wide));
    chk("tr0_ph", 64'h2, 64'(q_tph[0]));
    chk("be_copy", 64'(BE[7:4]), 64'(q_ph[1][67:64]));
    for (int i = 0; i < 4; i++) chk("wr_dw", 64'((A0 + 32'(4 * i)) ^ SEED), 64'(q_ph[i][31:0]));
  endtask
  task automatic scen_fb_read(input bit d);
    job(A0, 16'h4, `WNF_CMD_MEM_RD, 0, d, 0);
    chk("wide_cnt", 64'h1, 64'(n_wide));
    chk("rd_lo", {pat(1), pat(0)}, q_snk[0]);
    chk("rd_hi", {pat(3), pat(2)}, q_snk[1]);
    if (!d) chk("be_copy", 64'(BE[7:4]), 64'(q_ph[1][67:64]));
    if (!d) chk("tr0_ph", 64'h2, 64'(q_tph[0]));
    for (int i = 0; i < 4 && d; i++) chk("tr_ph", 64'h1, 64'(q_tph[i]));
    for (int i = 0; i < 4 && d; i++) chk("tr_addr", 64'(A0 + 32'(4 * i)), 64'(q_adr[i]));
  endtask
  task automatic scen_retry;
    job(A0, 16'h4, `WNF_CMD_MEM_RD, 1, 0, 1);
    chk("wide_cnt", 64'h2, 64'(n_wide));
    chk("retry_addr", 64'(A0), 64'(q_adr[1]));
    chk("retry_qw", {~pat(1), pat(1)}, q_snk[0]);
  endtask
  task automatic scen_narrow(input logic [3:0] c, input logic [31:0] a, input logic [15:0] dw);
    job(a, dw, c, 1, 0, 0);
    chk("narrow_only", 64'h0, 64'(n_wide));
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (60000) @(posedge MCLK);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge MCLK);
    @(negedge MCLK) RSTN <= 1'b1;
    repeat (3) @(negedge MCLK);
    scen_cmds();
    scen_fb_write();
    scen_fb_read(0);
    scen_fb_read(1);
    scen_retry();
    scen_narrow(4'h2, A0, 16'h4);
    scen_narrow(`WNF_CMD_MEM_RD, A0 + 32'h4, 16'h4);
    scen_narrow(`WNF_CMD_MEM_RD, A0, 16'h2);
    end_sim();
  end
endmodule // wide_initiator_narrow_fallback_tb
